// File: hdl/phy_irq_pkg.sv
// Purpose: Shared constants for the PHY event interrupt register block
// Assumes: 16-bit management data, 5-bit register address
// Notes: Flag bits sit in the low byte, enables in the high byte
package phy_irq_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned EVENT_N = 8;
   localparam logic [4:0] IRQ_CTL_STAT_ADDR = 5'h11;
   localparam logic [15:0] IRQ_CTL_STAT_RESET = 16'h0000;
   localparam int unsigned FLAG_LSB = 0;
   localparam int unsigned EN_LSB = 8;
   localparam int unsigned BIT_NEGOTIATION_DONE = 0;
   localparam int unsigned BIT_REMOTE_FAULT = 1;
   localparam int unsigned BIT_LINK_DROP = 2;
   localparam int unsigned BIT_PARTNER_ACK = 3;
   localparam int unsigned BIT_PARALLEL_DETECT_FAULT = 4;
   localparam int unsigned BIT_PAGE_ARRIVED = 5;
   localparam int unsigned BIT_RX_FAULT_EVENT = 6;
   localparam int unsigned BIT_JABBER_EVENT = 7;
endpackage : phy_irq_pkg

// File: hdl/event_flag_bank.sv
// Purpose: Sticky event flags, cleared on register read
// Assumes: Event inputs are one-cycle or level strobes synchronous to clock
// Notes: A new event beats a read clear in the same cycle
`timescale 1ns/1ps
module event_flag_bank #(
   parameter int unsigned N = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [N-1:0] event_in,
   input wire logic clear,
   output logic [N-1:0] flags
);
   logic [N-1:0] flag_reg;
   logic [N-1:0] flag_next;

   // ---------------------------------------------
   // Per-bit sticky flags
   // ---------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_flag
         // Set dominates clear so an event landing on a read is kept
         assign flag_next[i] = event_in[i] | (flag_reg[i] & ~clear);
      end
   endgenerate

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_reg <= '0;
      end
      else if (clk_en)
      begin
         flag_reg <= flag_next;
      end
   end

   assign flags = flag_reg;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   event_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en |=> (flag_reg & $past(event_in)) == $past(event_in))
      else $error("Event lost in flag bank");
   read_clears_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && clear && event_in == '0) |=> flag_reg == '0)
      else $error("Flags not cleared by read");
endmodule : event_flag_bank

// File: hdl/phy_event_interrupt_regs.sv
// Purpose: PHY interrupt control and status register on the management port
// Assumes: Management reads and writes arrive as single-cycle strobes
// Notes: Read data is registered; flags clear on the read strobe
// Notes on behaviour
// - Eight event flags in bits 0 to 7
// - Reading the register clears all flags except any whose event arrives in the read cycle
// - Enables bits 8-15 gate flags onto interrupt
// - Jabber sets bit 7, enabled by 15
// - Receive error sets bit 6, enabled by 14
// - Page received sets bit 5, enabled by 13
// - Parallel detect fault sets 4, enabled 12
// - Partner acknowledge sets bit 3, enabled 11
// - Link good-to-fail sets bit 2, enabled 10
// - Remote fault sets bit 1, enabled 9
// - Negotiation complete sets bit 0, enabled 8
// - Address 0x11, resets to all zeros
`timescale 1ns/1ps
module phy_event_interrupt_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [phy_irq_pkg::ADDR_W-1:0] mgmt_addr,
   input wire logic mgmt_rd,
   input wire logic mgmt_wr,
   input wire logic [phy_irq_pkg::DATA_W-1:0] mgmt_wdata,
   output logic [phy_irq_pkg::DATA_W-1:0] mgmt_rdata,
   input wire logic jabber_event,
   input wire logic rx_fault_event,
   input wire logic page_arrived,
   input wire logic parallel_detect_fault,
   input wire logic partner_ack,
   input wire logic link_ok,
   input wire logic remote_fault,
   input wire logic negotiation_done,
   output logic mac_raw_irq_status
);
   localparam int unsigned N = phy_irq_pkg::EVENT_N;

   // ---------------------------------------------
   // Event collection
   // ---------------------------------------------
   logic link_ok_reg;
   logic link_drop;
   logic [N-1:0] events;
   logic [N-1:0] flags;
   logic [N-1:0] en_reg;
   logic [N-1:0] en_next;
   logic [phy_irq_pkg::DATA_W-1:0] rdata_reg;
   logic [phy_irq_pkg::DATA_W-1:0] rdata_next;
   logic irq_reg;
   logic sel;
   logic rd_hit;
   logic wr_hit;
   logic [N-1:0] irq_src;
   logic jabber_event_flag;
   logic rx_fault_event_flag;
   logic page_arrived_flag;
   logic parallel_detect_fault_flag;
   logic partner_ack_flag;
   logic link_drop_flag;
   logic remote_fault_flag;
   logic negotiation_done_flag;
   logic jabber_event_en;
   logic rx_fault_event_en;
   logic page_arrived_en;
   logic parallel_detect_fault_en;
   logic partner_ack_en;
   logic link_drop_en;
   logic remote_fault_en;
   logic negotiation_done_en;

   // Only a good-to-failed transition counts, not recovery
   assign link_drop = link_ok_reg & ~link_ok;

   assign events[phy_irq_pkg::BIT_JABBER_EVENT] = jabber_event;
   assign events[phy_irq_pkg::BIT_RX_FAULT_EVENT] = rx_fault_event;
   assign events[phy_irq_pkg::BIT_PAGE_ARRIVED] = page_arrived;
   assign events[phy_irq_pkg::BIT_PARALLEL_DETECT_FAULT] = parallel_detect_fault;
   assign events[phy_irq_pkg::BIT_PARTNER_ACK] = partner_ack;
   assign events[phy_irq_pkg::BIT_LINK_DROP] = link_drop;
   assign events[phy_irq_pkg::BIT_REMOTE_FAULT] = remote_fault;
   assign events[phy_irq_pkg::BIT_NEGOTIATION_DONE] = negotiation_done;

   // ---------------------------------------------
   // Register decode
   // ---------------------------------------------
   assign sel = (mgmt_addr == phy_irq_pkg::IRQ_CTL_STAT_ADDR);
   assign rd_hit = sel & mgmt_rd;
   assign wr_hit = sel & mgmt_wr;
   // Flags are read-clear, so a write only touches the enable byte
   assign en_next = wr_hit ? mgmt_wdata[phy_irq_pkg::EN_LSB +: N] : en_reg;
   // Unmapped addresses read as zero and clear nothing
   assign rdata_next = rd_hit ? {en_reg, flags} : '0;

   event_flag_bank #(
      .N(N)
   ) u_flags (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .event_in(events),
      .clear(rd_hit),
      .flags(flags)
   );

   // ---------------------------------------------
   // Field views and interrupt sources
   // ---------------------------------------------
   // Named views keep the byte layout in one place for software-facing fields
   assign jabber_event_flag = flags[phy_irq_pkg::BIT_JABBER_EVENT];
   assign rx_fault_event_flag = flags[phy_irq_pkg::BIT_RX_FAULT_EVENT];
   assign page_arrived_flag = flags[phy_irq_pkg::BIT_PAGE_ARRIVED];
   assign parallel_detect_fault_flag = flags[phy_irq_pkg::BIT_PARALLEL_DETECT_FAULT];
   assign partner_ack_flag = flags[phy_irq_pkg::BIT_PARTNER_ACK];
   assign link_drop_flag = flags[phy_irq_pkg::BIT_LINK_DROP];
   assign remote_fault_flag = flags[phy_irq_pkg::BIT_REMOTE_FAULT];
   assign negotiation_done_flag = flags[phy_irq_pkg::BIT_NEGOTIATION_DONE];
   assign jabber_event_en = en_reg[phy_irq_pkg::BIT_JABBER_EVENT];
   assign rx_fault_event_en = en_reg[phy_irq_pkg::BIT_RX_FAULT_EVENT];
   assign page_arrived_en = en_reg[phy_irq_pkg::BIT_PAGE_ARRIVED];
   assign parallel_detect_fault_en = en_reg[phy_irq_pkg::BIT_PARALLEL_DETECT_FAULT];
   assign partner_ack_en = en_reg[phy_irq_pkg::BIT_PARTNER_ACK];
   assign link_drop_en = en_reg[phy_irq_pkg::BIT_LINK_DROP];
   assign remote_fault_en = en_reg[phy_irq_pkg::BIT_REMOTE_FAULT];
   assign negotiation_done_en = en_reg[phy_irq_pkg::BIT_NEGOTIATION_DONE];

   // Each enable gates only its own flag
   assign irq_src[phy_irq_pkg::BIT_JABBER_EVENT] =
      jabber_event_flag & jabber_event_en;
   assign irq_src[phy_irq_pkg::BIT_RX_FAULT_EVENT] =
      rx_fault_event_flag & rx_fault_event_en;
   assign irq_src[phy_irq_pkg::BIT_PAGE_ARRIVED] =
      page_arrived_flag & page_arrived_en;
   assign irq_src[phy_irq_pkg::BIT_PARALLEL_DETECT_FAULT] =
      parallel_detect_fault_flag & parallel_detect_fault_en;
   assign irq_src[phy_irq_pkg::BIT_PARTNER_ACK] =
      partner_ack_flag & partner_ack_en;
   assign irq_src[phy_irq_pkg::BIT_LINK_DROP] =
      link_drop_flag & link_drop_en;
   assign irq_src[phy_irq_pkg::BIT_REMOTE_FAULT] =
      remote_fault_flag & remote_fault_en;
   assign irq_src[phy_irq_pkg::BIT_NEGOTIATION_DONE] =
      negotiation_done_flag & negotiation_done_en;

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Link assumed down at reset so no drop is reported early
         link_ok_reg <= 1'b0;
         en_reg <= phy_irq_pkg::IRQ_CTL_STAT_RESET[phy_irq_pkg::EN_LSB +: N];
         rdata_reg <= '0;
         irq_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         link_ok_reg <= link_ok;
         en_reg <= en_next;
         rdata_reg <= rdata_next;
         irq_reg <= |irq_src;
      end
   end

   assign mgmt_rdata = rdata_reg;
   assign mac_raw_irq_status = irq_reg;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   irq_gating_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en |=> mac_raw_irq_status == |($past(flags) & $past(en_reg)))
      else $error("Interrupt does not match enabled flags");
   read_data_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && rd_hit) |=> mgmt_rdata == {$past(en_reg), $past(flags)})
      else $error("Read data wrong");
   read_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && rd_hit && events == '0) |=> flags == '0)
      else $error("Read did not clear flags");
   enable_write_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && wr_hit) |=> en_reg == $past(mgmt_wdata[phy_irq_pkg::EN_LSB +: N]))
      else $error("Enable byte not written");
   jabber_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && jabber_event) |=> flags[phy_irq_pkg::BIT_JABBER_EVENT])
      else $error("Jabber flag not set");
   rx_fault_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && rx_fault_event) |=> flags[phy_irq_pkg::BIT_RX_FAULT_EVENT])
      else $error("Receive error flag not set");
   page_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && page_arrived) |=> flags[phy_irq_pkg::BIT_PAGE_ARRIVED])
      else $error("Page flag not set");
   pdf_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && parallel_detect_fault) |=> flags[phy_irq_pkg::BIT_PARALLEL_DETECT_FAULT])
      else $error("Parallel detect flag not set");
   ack_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && partner_ack) |=> flags[phy_irq_pkg::BIT_PARTNER_ACK])
      else $error("Partner ack flag not set");
   link_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && link_ok_reg && !link_ok) |=> flags[phy_irq_pkg::BIT_LINK_DROP])
      else $error("Link drop flag not set");
   link_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && !link_ok_reg && link_ok && rd_hit) |=> !flags[phy_irq_pkg::BIT_LINK_DROP])
      else $error("Link recovery set drop flag");
   remote_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && remote_fault) |=> flags[phy_irq_pkg::BIT_REMOTE_FAULT])
      else $error("Remote fault flag not set");
   done_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && negotiation_done) |=> flags[phy_irq_pkg::BIT_NEGOTIATION_DONE])
      else $error("Negotiation flag not set");
   freeze_a: assert property (@(posedge clock) disable iff (!rst_n)
      !clk_en |=> $stable(flags) && $stable(en_reg))
      else $error("State moved with clock enable low");
   freeze_out_a: assert property (@(posedge clock) disable iff (!rst_n)
      !clk_en |=> $stable(mgmt_rdata) && $stable(mac_raw_irq_status))
      else $error("Outputs moved with clock enable low");
   reset_zero_a: assert property (@(posedge clock)
      !rst_n |-> flags == '0 && en_reg == '0 && mgmt_rdata == '0 && !mac_raw_irq_status)
      else $error("State not zero during reset");
   idle_rdata_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && !rd_hit) |=> mgmt_rdata == '0)
      else $error("Read data not zero after a non-hit cycle");
   miss_keeps_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && mgmt_rd && !sel) |=> (flags & $past(flags)) == $past(flags))
      else $error("Unmapped read cleared flags");
   miss_write_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && mgmt_wr && !sel) |=> $stable(en_reg))
      else $error("Unmapped write changed enables");
   no_false_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && events == '0) |=> (flags & ~$past(flags)) == '0)
      else $error("Flag set with no event");
   flag_byte_ro_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && wr_hit && !rd_hit && events == '0) |=> flags == $past(flags))
      else $error("Write changed the flag byte");
   irq_masked_a: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && en_reg == '0) |=> !mac_raw_irq_status)
      else $error("Interrupt raised with no enable set");

   read_cov: cover property (@(posedge clock) disable iff (!rst_n)
      clk_en && rd_hit && flags != '0);
   irq_cov: cover property (@(posedge clock) disable iff (!rst_n) $rose(mac_raw_irq_status));
   race_cov: cover property (@(posedge clock) disable iff (!rst_n)
      clk_en && rd_hit && events != '0);
   freeze_cov: cover property (@(posedge clock) disable iff (!rst_n) !clk_en && rd_hit);
   link_cov: cover property (@(posedge clock) disable iff (!rst_n)
      clk_en && link_drop && !rd_hit);
endmodule : phy_event_interrupt_regs

// File: verif/mgmt_host_model.sv
// Purpose: Management host model for the PHY event register
// Assumes: One-cycle strobes launched at the falling edge
// Notes: Address and write data go to inverted values when idle, strobes to zero, so stale data never looks valid
`timescale 1ns/1ps
module mgmt_host_model (
   input wire logic clock,
   output logic [4:0] mgmt_addr,
   output logic mgmt_rd,
   output logic mgmt_wr,
   output logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata
);
   initial
   begin
      mgmt_addr = 5'h00;
      mgmt_rd = 1'b0;
      mgmt_wr = 1'b0;
      mgmt_wdata = 16'h0000;
   end
   // Reads or writes any address; data taken at the falling edge after the strobe
   task access(input logic [4:0] a, input logic w, input logic [15:0] d,
               output logic [15:0] q);
      @(negedge clock);
      mgmt_addr = a;
      mgmt_wr = w;
      mgmt_rd = !w;
      mgmt_wdata = d;
      @(negedge clock);
      mgmt_rd = 1'b0;
      mgmt_wr = 1'b0;
      mgmt_addr = ~a;
      mgmt_wdata = ~d;
      q = mgmt_rdata;
   endtask : access
endmodule : mgmt_host_model

// File: verif/phy_event_interrupt_regs_test.sv
// Purpose: Self-checking bench for the PHY event register
// Assumes: Inputs change at the falling edge
// Notes: Bit 2 event is made by dropping link_ok for one cycle
`timescale 1ns/1ps
module phy_event_interrupt_regs_test;
   logic clock;
   logic rst_n;
   logic clk_en;
   logic [7:0] ev;
   logic [4:0] mgmt_addr;
   logic mgmt_rd;
   logic mgmt_wr;
   logic [15:0] mgmt_wdata;
   logic [15:0] mgmt_rdata;
   logic irq;
   logic [15:0] q;
   int n_errors;
   int n_checks;
   phy_event_interrupt_regs dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
      .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .jabber_event(ev[7]),
      .rx_fault_event(ev[6]), .page_arrived(ev[5]), .parallel_detect_fault(ev[4]),
      .partner_ack(ev[3]), .link_ok(~ev[2]), .remote_fault(ev[1]),
      .negotiation_done(ev[0]), .mac_raw_irq_status(irq));
   mgmt_host_model host (.clock(clock), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
      .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task rd(input logic [4:0] a);
      host.access(a, 1'b0, 16'h0000, q);
   endtask : rd
   task wr(input logic [4:0] a, input logic [15:0] d);
      host.access(a, 1'b1, d, q);
   endtask : wr
   task pulse(input logic [7:0] m);
      @(negedge clock);
      ev = m;
      @(negedge clock);
      ev = 8'h00;
   endtask : pulse
   task wrap_up;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task test_flags;
      for (int i = 0; i < 8; i++)
      begin
         pulse(8'h01 << i);
         rd(5'h11);
         chk(q, 16'h0001 << i);
         rd(5'h11);
         chk(q, 16'h0000);
      end
      $display("flag test done");
   endtask : test_flags
   task test_irq;
      for (int i = 0; i < 8; i++)
      begin
         wr(5'h11, 16'h0100 << i);
         pulse(8'h01 << ((i + 1) % 8));
         @(negedge clock);
         chk({15'h0000, irq}, 16'h0000);
         pulse(8'h01 << i);
         @(negedge clock);
         chk({15'h0000, irq}, 16'h0001);
         rd(5'h11);
         chk(q, (16'h0101 << i) | (16'h0001 << ((i + 1) % 8)));
         @(negedge clock);
         chk({15'h0000, irq}, 16'h0000);
      end
      $display("irq test done");
   endtask : test_irq
   task test_refuse;
      pulse(8'h80);
      wr(5'h12, 16'hffff);
      rd(5'h12);
      chk(q, 16'h0000);
      wr(5'h11, 16'h00ff);
      rd(5'h11);
      chk(q, 16'h0080);
      $display("address test done");
   endtask : test_refuse
   task test_race;
      fork
         rd(5'h11);
         pulse(8'h40);
      join
      chk(q, 16'h0000);
      rd(5'h11);
      chk(q, 16'h0040);
      $display("race test done");
   endtask : test_race
   task test_link;
      fork
         pulse(8'h04);
         begin
            @(negedge clock);
            rd(5'h11);
         end
      join
      chk(q, 16'h0004);
      rd(5'h11);
      chk(q, 16'h0000);
      $display("link test done");
   endtask : test_link
   task test_freeze;
      wr(5'h11, 16'h4000);
      @(negedge clock);
      clk_en = 1'b0;
      pulse(8'h40);
      rd(5'h11);
      chk(q, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      @(negedge clock);
      clk_en = 1'b1;
      rd(5'h11);
      chk(q, 16'h4000);
      $display("freeze test done");
   endtask : test_freeze
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Every wait is a fixed count, so this only catches a stuck simulator
   initial
   begin
      #200000;
      n_errors++;
      wrap_up;
   end
   initial
   begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      ev = 8'h00;
      n_errors = 0;
      n_checks = 0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      rd(5'h11);
      chk(q, 16'h0000);
      test_flags;
      test_irq;
      test_refuse;
      test_race;
      test_link;
      test_freeze;
      wrap_up;
   end
endmodule : phy_event_interrupt_regs_test
